// ===== include/mdr_pkg.sv
// mode register bank constants, field layouts and carrier types
package mdr_pkg;
  localparam int          CLK_MHZ            = 10;
  localparam int          AUTO_INIT_MAX_US   = 10;
  localparam int          AUTO_INIT_CYCLES   = AUTO_INIT_MAX_US * CLK_MHZ;
  localparam int          CAL_TIME_US        = 1;
  localparam int          CAL_CYCLES         = CAL_TIME_US * CLK_MHZ;
  localparam logic [3:0]  READ_LATENCY       = 4'h2;
  localparam logic [7:0]  ADDR_DEV_INFO      = 8'h00;
  localparam logic [7:0]  ADDR_FEATURE_ONE   = 8'h01;
  localparam logic [7:0]  ADDR_FEATURE_TWO   = 8'h02;
  localparam logic [7:0]  ADDR_IO_CONFIG     = 8'h03;
  localparam logic [7:0]  ADDR_REFRESH_RATE  = 8'h04;
  localparam logic [7:0]  ADDR_MAKER_ID      = 8'h05;
  localparam logic [7:0]  ADDR_REVISION_ONE  = 8'h06;
  localparam logic [7:0]  ADDR_REVISION_TWO  = 8'h07;
  localparam logic [7:0]  ADDR_GEOMETRY      = 8'h08;
  localparam logic [7:0]  ADDR_TEST_MODE     = 8'h09;
  localparam logic [7:0]  ADDR_CALIBRATION   = 8'h0A;
  localparam logic [7:0]  ADDR_BANK_MASK     = 8'h10;
  localparam logic [7:0]  ADDR_SEGMENT_MASK  = 8'h11;
  localparam logic [7:0]  ADDR_PATTERN_A     = 8'h20;
  localparam logic [7:0]  ADDR_PATTERN_B     = 8'h28;
  localparam logic [7:0]  ADDR_DEVICE_RESET  = 8'h3F;
  localparam int          DI_AUTO_INIT_BIT   = 0;
  localparam int          DI_KIND_BIT        = 1;
  localparam int          DI_DNV_BIT         = 2;
  localparam int          DI_ZQ_LSB          = 3;
  localparam logic [1:0]  ZQ_NOT_SUPPORTED   = 2'h0;
  localparam logic [1:0]  ZQ_TIED_HIGH       = 2'h1;
  localparam logic [1:0]  ZQ_GROUNDED        = 2'h2;
  localparam logic [1:0]  ZQ_PASSED          = 2'h3;
  localparam logic [2:0]  BURST_LEN_4        = 3'h2;
  localparam logic [2:0]  BURST_LEN_8        = 3'h3;
  localparam logic [2:0]  BURST_LEN_16       = 3'h4;
  localparam logic [7:0]  FEATURE_ONE_RESET  = 8'h22;
  localparam logic [7:0]  FEATURE_TWO_RESET  = 8'h01;
  localparam logic [7:0]  IO_CONFIG_RESET    = 8'h02;
  localparam logic [7:0]  FEATURE_TWO_MASK   = 8'h0F;
  localparam logic [7:0]  IO_CONFIG_MASK     = 8'h0F;
  localparam logic [7:0]  CAL_CODE_INIT      = 8'hFF;

  typedef struct packed {
    logic       mode_reg_read_cmd;
    logic       mode_reg_write_cmd;
    logic [7:0] register_address;
    logic [7:0] op;
  } mdr_cmd_t;

  typedef struct packed {
    logic [7:0] dq;
    logic       dq_oe;
    logic       strobe;
    logic       strobe_oe;
  } mdr_rd_t;

  typedef enum logic [1:0] {
    MDR_INIT = 2'b00,
    MDR_IDLE = 2'b01,
    MDR_CAL  = 2'b10
  } mdr_state_t;
endpackage : mdr_pkg

// ===== design/mdr_mode_register_bank.sv
// mode register bank: decode, storage, access classes and read return
// Function
// - data and strobe pins stay high impedance while clock enable is low.
// - read and write commands honour each register's access class.
// - implemented registers sit at the fixed documented addresses.
// - reset-register write resets device; calibration write starts calibration.
// - reserved bits of implemented registers read back as zero.
// - reads of write-only or reserved registers still toggle the strobe.
// - writes to read-only registers change nothing.
// - device information reports init status, kind, invalid-data support.
// - device information bits 4:3 give impedance self-test result.
// - self-test field updates when initial calibration completes.
// - self-test failure keeps factory trim and ignores later calibration.
// - feature register one bits 2:0 select burst length 4, 8, 16.
// - init status clears within ten microseconds of the reset command.
`timescale 1ns/100ps
module mdr_mode_register_bank
  import mdr_pkg::*;
#(
  parameter int         AUTO_INIT_LEN  = AUTO_INIT_CYCLES,
  parameter int         CAL_LEN        = CAL_CYCLES,
  parameter logic       NONVOLATILE    = 1'b0,
  parameter logic       ZQ_TEST_SUPPORT = 1'b1,
  // identification values below are arbitrary
  parameter logic [7:0] MAKER_ID       = 8'h5A,
  parameter logic [7:0] REVISION_ONE   = 8'h01,
  parameter logic [7:0] REVISION_TWO   = 8'h00,
  parameter logic [7:0] GEOMETRY       = 8'h14,
  parameter logic [7:0] REFRESH_STATUS = 8'h03,
  parameter logic [7:0] PATTERN_A      = 8'h55,
  parameter logic [7:0] PATTERN_B      = 8'hAA
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       clock_enable,
  input  wire mdr_cmd_t   cmd,
  input  wire logic [1:0] zq_pin_sense,
  output mdr_rd_t         rd,
  output logic [2:0]      burst_length_select,
  output logic            burst_order_select,
  output logic            wrap_select,
  output logic [2:0]      write_recovery_cycles,
  output logic            factory_trim_active,
  output logic [7:0]      impedance_code,
  output logic            device_busy
);

  mdr_state_t  state_r;
  logic [15:0] timer_r;
  logic        auto_init_status_r;
  logic [1:0]  impedance_selftest_result_r;
  logic        zq_tested_r;
  logic [7:0]  feature_one_r;
  logic [7:0]  feature_two_r;
  logic [7:0]  io_config_r;
  logic [7:0]  test_mode_r;
  logic [7:0]  bank_mask_r;
  logic [7:0]  segment_mask_r;
  logic [7:0]  cal_code_r;
  logic [1:0]  zq_meta_r;
  logic [1:0]  zq_sync_r;
  logic        cke_meta_r;
  logic        cke_sync_r;
  logic [3:0]  rd_cnt_r;
  logic [7:0]  rd_data_r;
  logic        rd_pend_r;
  logic        strobe_r;

  logic        cmd_rd;
  logic        cmd_wr;
  logic        wr_reset_cmd;
  logic        wr_cal_cmd;
  logic [7:0]  dev_info;
  logic [7:0]  rd_mux;
  logic        init_done;
  logic        cal_done;
  logic        rd_take;
  logic        bl_code_ok;
  logic        wr_feature_one;
  logic        wr_feature_two;
  logic        wr_io_config;
  logic        wr_test_mode;
  logic        wr_bank_mask;
  logic        wr_segment_mask;

  // clock enable comes from a pin: two flops before any logic reads it
  always_ff @(posedge clock) begin
    if (reset) begin
      cke_meta_r <= 1'b0;
      cke_sync_r <= 1'b0;
    end else begin
      cke_meta_r <= clock_enable;
      cke_sync_r <= cke_meta_r;
    end
  end

  // the zq sense pad is sampled the same way; only the second flop is read
  always_ff @(posedge clock) begin
    if (reset) begin
      zq_meta_r <= 2'h0;
      zq_sync_r <= 2'h0;
    end else begin
      zq_meta_r <= zq_pin_sense;
      zq_sync_r <= zq_meta_r;
    end
  end

  // commands only count while clock enable is high
  assign cmd_rd = cmd.mode_reg_read_cmd & cke_sync_r;
  assign cmd_wr = cmd.mode_reg_write_cmd & cke_sync_r & ~cmd.mode_reg_read_cmd;
  // reset register write starts a device reset
  assign wr_reset_cmd = cmd_wr && (cmd.register_address == ADDR_DEVICE_RESET);
  // calibration commands ignored once factory trim is in force
  assign wr_cal_cmd = cmd_wr && (cmd.register_address == ADDR_CALIBRATION)
                      && !factory_trim_active && (state_r == MDR_IDLE);

  // end points of the two timed phases
  assign init_done = (state_r == MDR_INIT) && (timer_r >= 16'(AUTO_INIT_LEN - 1));
  assign cal_done  = (state_r == MDR_CAL) && (timer_r >= 16'(CAL_LEN - 1));

  // reset command restarts the flow at the auto-initialization step
  always_ff @(posedge clock) begin
    if (reset || wr_reset_cmd) begin
      state_r <= MDR_INIT;
      timer_r <= 16'h0000;
    end else begin
      unique case (state_r)
        MDR_INIT: begin
          if (init_done) begin
            state_r <= MDR_IDLE;
            timer_r <= 16'h0000;
          end else begin
            timer_r <= timer_r + 16'h0001;
          end
        end
        MDR_IDLE: begin
          if (wr_cal_cmd) begin
            state_r <= MDR_CAL;
            timer_r <= 16'h0000;
          end
        end
        MDR_CAL: begin
          if (cal_done) begin
            state_r <= MDR_IDLE;
            timer_r <= 16'h0000;
          end else begin
            timer_r <= timer_r + 16'h0001;
          end
        end
        default: begin
          state_r <= MDR_INIT;
          timer_r <= 16'h0000;
        end
      endcase
    end
  end

  // init status set by every reset, cleared once the init count ends
  always_ff @(posedge clock) begin
    if (reset || wr_reset_cmd) begin
      auto_init_status_r <= 1'b1;
    end else if (init_done) begin
      auto_init_status_r <= 1'b0;
    end
  end

  // self-test result latched when the first calibration completes
  always_ff @(posedge clock) begin
    if (reset) begin
      impedance_selftest_result_r <= ZQ_NOT_SUPPORTED;
      zq_tested_r                 <= 1'b0;
    end else if (ZQ_TEST_SUPPORT && (state_r == MDR_CAL) && !zq_tested_r
                 && (timer_r >= 16'(CAL_LEN - 1))) begin
      impedance_selftest_result_r <= zq_sync_r;
      zq_tested_r                 <= 1'b1;
    end
  end

  // a failed self test pins the output impedance to factory trim
  assign factory_trim_active = (impedance_selftest_result_r == ZQ_TIED_HIGH)
                            || (impedance_selftest_result_r == ZQ_GROUNDED);
  assign impedance_code = factory_trim_active ? CAL_CODE_INIT : cal_code_r;
  assign device_busy    = (state_r != MDR_IDLE);

  // one strobe per write-class address; others store nothing
  assign wr_feature_one  = cmd_wr && (cmd.register_address == ADDR_FEATURE_ONE);
  assign wr_feature_two  = cmd_wr && (cmd.register_address == ADDR_FEATURE_TWO);
  assign wr_io_config    = cmd_wr && (cmd.register_address == ADDR_IO_CONFIG);
  assign wr_test_mode    = cmd_wr && (cmd.register_address == ADDR_TEST_MODE);
  assign wr_bank_mask    = cmd_wr && (cmd.register_address == ADDR_BANK_MASK);
  assign wr_segment_mask = cmd_wr && (cmd.register_address == ADDR_SEGMENT_MASK);
  // a reserved burst code drops the whole feature-one write
  assign bl_code_ok = (cmd.op[2:0] == BURST_LEN_4) || (cmd.op[2:0] == BURST_LEN_8)
                   || (cmd.op[2:0] == BURST_LEN_16);

  always_ff @(posedge clock) begin
    if (reset || wr_reset_cmd) begin
      feature_one_r <= FEATURE_ONE_RESET;
    end else if (wr_feature_one && bl_code_ok) begin
      feature_one_r <= cmd.op;
    end
  end

  // reserved upper bits of feature two and io config are never stored
  always_ff @(posedge clock) begin
    if (reset || wr_reset_cmd) begin
      feature_two_r <= FEATURE_TWO_RESET;
    end else if (wr_feature_two) begin
      feature_two_r <= cmd.op & FEATURE_TWO_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (reset || wr_reset_cmd) begin
      io_config_r <= IO_CONFIG_RESET;
    end else if (wr_io_config) begin
      io_config_r <= cmd.op & IO_CONFIG_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (reset || wr_reset_cmd) begin
      test_mode_r <= 8'h00;
    end else if (wr_test_mode) begin
      test_mode_r <= cmd.op;
    end
  end

  always_ff @(posedge clock) begin
    if (reset || wr_reset_cmd) begin
      bank_mask_r <= 8'h00;
    end else if (wr_bank_mask) begin
      bank_mask_r <= cmd.op;
    end
  end

  always_ff @(posedge clock) begin
    if (reset || wr_reset_cmd) begin
      segment_mask_r <= 8'h00;
    end else if (wr_segment_mask) begin
      segment_mask_r <= cmd.op;
    end
  end

  // a calibration write ignored under factory trim leaves the code alone
  always_ff @(posedge clock) begin
    if (reset || wr_reset_cmd) begin
      cal_code_r <= CAL_CODE_INIT;
    end else if (wr_cal_cmd) begin
      cal_code_r <= cmd.op;
    end
  end

  // burst length and the other feature-one fields
  assign burst_length_select   = feature_one_r[2:0];
  assign burst_order_select    = feature_one_r[3];
  assign wrap_select           = feature_one_r[4];
  assign write_recovery_cycles = feature_one_r[7:5];

  // device information layout; upper bits read zero
  assign dev_info = {3'h0, impedance_selftest_result_r, 1'b0, NONVOLATILE,
                     auto_init_status_r};

  // read-class decode; others return zero, still strobed
  always_comb begin
    unique case (cmd.register_address)
      ADDR_DEV_INFO: begin
        rd_mux = dev_info;
      end
      ADDR_REFRESH_RATE: begin
        rd_mux = REFRESH_STATUS;
      end
      ADDR_MAKER_ID: begin
        rd_mux = MAKER_ID;
      end
      ADDR_REVISION_ONE: begin
        rd_mux = REVISION_ONE;
      end
      ADDR_REVISION_TWO: begin
        rd_mux = REVISION_TWO;
      end
      ADDR_GEOMETRY: begin
        rd_mux = GEOMETRY;
      end
      ADDR_PATTERN_A: begin
        rd_mux = PATTERN_A;
      end
      ADDR_PATTERN_B: begin
        rd_mux = PATTERN_B;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // a read is taken only while none is pending
  assign rd_take = cmd_rd && !rd_pend_r;

  // read data captured at the taking edge and held until the next read; cleared while clock enable is low
  always_ff @(posedge clock) begin
    if (reset || !cke_sync_r) begin
      rd_data_r <= 8'h00;
    end else if (rd_take) begin
      rd_data_r <= rd_mux;
    end
  end

  // fixed latency counter; clock enable low aborts a read in flight
  always_ff @(posedge clock) begin
    if (reset || !cke_sync_r) begin
      rd_pend_r <= 1'b0;
      rd_cnt_r  <= 4'h0;
    end else if (rd_take) begin
      rd_pend_r <= 1'b1;
      rd_cnt_r  <= 4'h0;
    end else if (rd_pend_r) begin
      rd_cnt_r <= rd_cnt_r + 4'h1;
      if (rd_cnt_r == READ_LATENCY + 4'h1) begin
        rd_pend_r <= 1'b0;
      end
    end
  end

  // strobe toggles for every read, whatever the address class
  always_ff @(posedge clock) begin
    if (reset || !cke_sync_r || rd_take) begin
      strobe_r <= 1'b0;
    end else if (rd_pend_r && (rd_cnt_r >= READ_LATENCY)) begin
      strobe_r <= ~strobe_r;
    end else if (!rd_pend_r) begin
      strobe_r <= 1'b0;
    end
  end

  // no pin is driven while clock enable is low
  assign rd.dq        = rd_data_r;
  assign rd.dq_oe     = rd_pend_r && cke_sync_r && (rd_cnt_r > READ_LATENCY - 4'h1);
  assign rd.strobe    = strobe_r;
  assign rd.strobe_oe = rd.dq_oe;

endmodule : mdr_mode_register_bank

// ===== test/mdr_bank_asserts.sv
// concurrent checks on the mode register bank ports
`timescale 1ns/100ps
module mdr_bank_asserts
  import mdr_pkg::*;
(
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       clock_enable,
  input wire mdr_cmd_t   cmd,
  input wire mdr_rd_t    rd,
  input wire logic [2:0] burst_length_select,
  input wire logic       factory_trim_active,
  input wire logic [7:0] impedance_code,
  input wire logic       device_busy
);
  localparam int INIT_LIM = 9;
  logic [1:0] ce_q;
  logic       ce_ok;
  logic       wr_any;
  logic       bl_ok;
  // commands count only once enable has crossed the synchroniser
  always_ff @(posedge clock) begin
    ce_q <= {ce_q[0], clock_enable};
  end
  assign ce_ok  = clock_enable && (ce_q == 2'h3);
  assign wr_any = ce_ok && cmd.mode_reg_write_cmd && !cmd.mode_reg_read_cmd;
  assign bl_ok  = cmd.op[2:0] inside {BURST_LEN_4, BURST_LEN_8, BURST_LEN_16};
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence strobe_pulse;
    !rd.strobe ##1 rd.strobe ##1 (!rd.strobe && !rd.dq_oe);
  endsequence
  // busy length fixed at the bench's calibration length of 3
  sequence cal_run;
    device_busy[*3] ##1 !device_busy;
  endsequence
  oe_pair_a: assert property (rd.strobe_oe == rd.dq_oe)
    else $error("strobe enable differs from data enable");
  hiz_ce_a: assert property (!clock_enable[*4] |-> !rd.dq_oe)
    else $error("output driven with clock enable low");
  read_origin_a: assert property ($rose(rd.dq_oe) |-> $past(cmd.mode_reg_read_cmd, 3))
    else $error("read return without a read three cycles before");
  read_window_a: assert property (disable iff (reset || !clock_enable)
    $rose(rd.dq_oe) |-> strobe_pulse) else $error("read strobe pattern wrong");
  burst_set_a: assert property (wr_any && cmd.register_address == ADDR_FEATURE_ONE
    && bl_ok |=> burst_length_select == $past(cmd.op[2:0])) else $error("burst code lost");
  burst_keep_a: assert property (wr_any && cmd.register_address == ADDR_FEATURE_ONE
    && !bl_ok |=> $stable(burst_length_select)) else $error("reserved burst code taken");
  cal_busy_a: assert property (wr_any && cmd.register_address == ADDR_CALIBRATION
    && !device_busy && !factory_trim_active |=> cal_run) else $error("calibration length");
  trim_ignore_a: assert property (wr_any && cmd.register_address == ADDR_CALIBRATION
    && !device_busy && factory_trim_active |=> !device_busy) else $error("calibration ran");
  trim_code_a: assert property (factory_trim_active |-> impedance_code == CAL_CODE_INIT)
    else $error("factory trim without default code");
  reset_reg_a: assert property (wr_any && cmd.register_address == ADDR_DEVICE_RESET
    |=> device_busy && burst_length_select == BURST_LEN_4) else $error("reset write no effect");
  init_bound_a: assert property ($fell(reset) |-> ##[0:INIT_LIM] !device_busy)
    else $error("auto init too long");
endmodule : mdr_bank_asserts

bind mdr_mode_register_bank mdr_bank_asserts mdr_bank_asserts_inst (.clock(clock),
  .reset(reset), .clock_enable(clock_enable), .cmd(cmd), .rd(rd),
  .burst_length_select(burst_length_select), .factory_trim_active(factory_trim_active),
  .impedance_code(impedance_code), .device_busy(device_busy));

// ===== test/mdr_ctrl_model.sv
// memory controller model issuing register reads and writes
`timescale 1ns/100ps
module mdr_ctrl_model
  import mdr_pkg::*;
(
  input  wire logic    clock,
  input  wire mdr_rd_t rd,
  output mdr_cmd_t     cmd
);
  initial cmd = '0;
  // callers also send reserved burst codes and writes to read-only addresses
  task automatic mode_reg_write_cmd(input logic [7:0] a, input logic [7:0] v);
    @(negedge clock);
    cmd = '{1'b0, 1'b1, a, v};
    // released bus shows the inverse so stale values cannot pass
    @(negedge clock);
    cmd = '{1'b0, 1'b0, ~a, ~v};
  endtask : mode_reg_write_cmd
  task automatic mode_reg_read_cmd(input logic [7:0] a, output logic [7:0] v, output logic [3:0] s);
    @(negedge clock);
    cmd = '{1'b1, 1'b0, a, 8'h00};
    @(negedge clock);
    cmd = '{1'b0, 1'b0, ~a, 8'hFF};
    repeat (2) @(negedge clock);
    s[3] = rd.dq_oe;
    @(negedge clock);
    s[2] = rd.strobe;
    @(negedge clock);
    s[1] = rd.strobe;
    s[0] = rd.dq_oe;
    v = rd.dq;
  endtask : mode_reg_read_cmd
endmodule : mdr_ctrl_model

// ===== test/tb.sv
// self-checking bench for the mode register bank
`timescale 1ns/100ps
module tb;
  import mdr_pkg::*;
  logic       clock, reset, clock_enable, burst_order_select, wrap_select;
  logic       factory_trim_active, device_busy;
  logic [1:0] zq_pin_sense;
  logic [2:0] burst_length_select, write_recovery_cycles;
  logic [7:0] impedance_code, d, op;
  logic [3:0] s;
  mdr_cmd_t   cmd;
  mdr_rd_t    rd;
  int         err_total, comparisons;
  logic [2:0] bl [3] = '{BURST_LEN_4, BURST_LEN_8, BURST_LEN_16};
  logic [7:0] ra [10] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h04, 8'h20, 8'h28, 8'h01, 8'h0B, 8'h7F};
  logic [7:0] rv [10] = '{8'h5A, 8'h01, 8'h00, 8'h14, 8'h03, 8'h55, 8'hAA, 8'h00, 8'h00, 8'h00};
  `define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
  mdr_mode_register_bank #(.AUTO_INIT_LEN(8), .CAL_LEN(3)) mdr_mode_register_bank_inst (
    .clock(clock), .reset(reset), .clock_enable(clock_enable), .cmd(cmd),
    .zq_pin_sense(zq_pin_sense), .rd(rd), .burst_length_select(burst_length_select),
    .burst_order_select(burst_order_select), .wrap_select(wrap_select),
    .write_recovery_cycles(write_recovery_cycles), .factory_trim_active(factory_trim_active),
    .impedance_code(impedance_code), .device_busy(device_busy));
  mdr_ctrl_model mdr_ctrl_model_inst (.clock(clock), .rd(rd), .cmd(cmd));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic end_sim();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    mdr_ctrl_model_inst.mode_reg_write_cmd(a, v);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    mdr_ctrl_model_inst.mode_reg_read_cmd(a, d, s);
    `CHK(s, 4'hC)
    `CHK(d & m, e)
  endtask : rdc
  initial begin
    #(100 * 3000);
    err_total++;
    end_sim();
  end
  initial begin
    reset = 1'b1;
    clock_enable = 1'b0;
    zq_pin_sense = ZQ_PASSED;
    err_total = 0;
    comparisons = 0;
    repeat (20) @(negedge clock);
    `CHK(rd.dq_oe, 1'b0)
    reset = 1'b0;
    clock_enable = 1'b1;
    repeat (2) @(negedge clock);
    rdc(ADDR_DEV_INFO, 8'hE7, 8'h01);
    repeat (3) @(negedge clock);
    rdc(ADDR_DEV_INFO, 8'hE7, 8'h00);
    foreach (bl[i]) begin
      op = {3'h2, i[0], ~i[0], bl[i]};
      wr(ADDR_FEATURE_ONE, op);
      `CHK({write_recovery_cycles, wrap_select, burst_order_select, burst_length_select}, op)
    end
    wr(ADDR_FEATURE_ONE, 8'h27);
    `CHK({write_recovery_cycles, wrap_select, burst_order_select, burst_length_select}, op)
    wr(ADDR_DEV_INFO, 8'hFF);
    wr(ADDR_MAKER_ID, 8'h00);
    foreach (ra[i]) rdc(ra[i], 8'hFF, rv[i]);
    wr(ADDR_CALIBRATION, 8'h3C);
    `CHK(device_busy, 1'b1)
    repeat (4) @(negedge clock);
    `CHK({device_busy, factory_trim_active}, 2'h0)
    `CHK(impedance_code, 8'h3C)
    rdc(ADDR_DEV_INFO, 8'hFF, 8'h18);
    wr(ADDR_DEVICE_RESET, 8'h00);
    `CHK({device_busy, burst_length_select, impedance_code}, {1'b1, BURST_LEN_4, CAL_CODE_INIT})
    d = 8'h01;
    // poll init status after reset write
    for (int n = 0; n < 4 && d[0] !== 1'b0; n++) rdc(ADDR_DEV_INFO, 8'hFE, 8'h18);
    `CHK(d, 8'h18)
    reset = 1'b1;
    @(negedge clock);
    reset = 1'b0;
    zq_pin_sense = ZQ_TIED_HIGH;
    repeat (10) @(negedge clock);
    wr(ADDR_CALIBRATION, 8'hFF);
    repeat (5) @(negedge clock);
    `CHK({factory_trim_active, impedance_code}, {1'b1, CAL_CODE_INIT})
    rdc(ADDR_DEV_INFO, 8'hFF, 8'h08);
    wr(ADDR_CALIBRATION, 8'hFF);
    `CHK(device_busy, 1'b0)
    clock_enable = 1'b0;
    repeat (4) @(negedge clock);
    mdr_ctrl_model_inst.mode_reg_read_cmd(ADDR_MAKER_ID, d, s);
    `CHK(s, 4'h0)
    end_sim();
  end
endmodule : tb
